// *** rtl/ies_pkg.sv ***
package ies_pkg;
    // datapath widths
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 7;
    localparam int PC_W    = 13;
    localparam int INSTR_W = 14;
    localparam int REGS    = 128;
    localparam int LIT_W   = 11;

    // instruction word fields
    localparam int OP_HI   = 13;
    localparam int OP_LO   = 8;
    localparam int DEST_B  = 7;
    localparam int BR_HI   = 13;
    localparam int BR_LO   = 11;

    // upper-address latch bits copied into the program counter top
    localparam int LATCH_HI = 4;
    localparam int LATCH_LO = 3;

    // six-bit major codes (encodings are arbitrary)
    localparam logic [5:0] OPC_CLEAR_LOC = 6'h01;
    localparam logic [5:0] OPC_CLEAR_ACC = 6'h02;
    localparam logic [5:0] OPC_DEC       = 6'h03;
    localparam logic [5:0] OPC_DEC_SKIP  = 6'h0b;
    localparam logic [5:0] OPC_INC_SKIP  = 6'h0f;
    localparam logic [5:0] OPC_OR_LIT    = 6'h38;
    // three-bit prefix of the branch word (arbitrary)
    localparam logic [2:0] OPC_BRANCH    = 3'h5;

    // destination select values
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_REG = 1'b1;

    // reset values and constants
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE  = 8'h01;
    localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
    localparam logic [PC_W-1:0]   PC_STEP   = 13'h0001;

    // decoded operation classes
    typedef enum logic [2:0] {
        IES_NOP,
        IES_CLEAR_LOC,
        IES_CLEAR_ACC,
        IES_DEC,
        IES_DEC_SKIP,
        IES_INC_SKIP,
        IES_BRANCH,
        IES_OR_LIT
    } ies_op_e;
endpackage : ies_pkg

// *** rtl/ies_core.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// RQ1: clear location writes zero, sets zero flag
// RQ2: clear accumulator loads zero, sets zero flag
// RQ3: destination bit picks accumulator or register
// RQ4: decrement stores result, updates zero only
// RQ5: decrement-skip leaves flags, skips on zero
// RQ6: increment-skip leaves flags, skips on zero
// RQ7: nonzero skip result runs next normally
// RQ8: branch loads immediate plus latch bits
// RQ9: branch takes two cycles, flags kept
// RQ10: or literal into accumulator, zero updated
// RQ11: zero flag follows eight-bit result
module ies_core (
    input  wire logic                          clk_in,
    input  wire logic                          rst_in,
    input  wire logic                          instr_valid_in,
    input  wire logic [ies_pkg::INSTR_W-1:0]   instr_in,
    input  wire logic [ies_pkg::DATA_W-1:0]    upper_latch_in,
    input  wire logic [ies_pkg::ADDR_W-1:0]    peek_addr_in,
    output logic      [ies_pkg::DATA_W-1:0]    acc_out,
    output logic                               zero_out,
    output logic      [ies_pkg::PC_W-1:0]      program_counter_out,
    output logic                               discard_out,
    output logic                               retired_out,
    output logic      [ies_pkg::DATA_W-1:0]    peek_data_out
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // zero test shared by the decrement, or-literal and skip paths; the clears set the flag directly
    // one function, so decrement and or can never disagree on it
    function automatic logic is_zero(input logic [ies_pkg::DATA_W-1:0] v);
        is_zero = (v == ies_pkg::ZERO_BYTE);
    endfunction : is_zero

    ////////////////////////////////////////////////////////////////////////////
    // state

    // register file has no reset; a read before a write returns unknown
    // control state below resets to an idle core
    logic [ies_pkg::DATA_W-1:0] regs_mem [ies_pkg::REGS]; // data register file
    logic [ies_pkg::DATA_W-1:0] acc_r;                    // accumulator
    logic [ies_pkg::DATA_W-1:0] acc_nxt;
    logic                       zero_r;                   // zero status flag
    logic                       zero_nxt;
    logic [ies_pkg::PC_W-1:0]   pc_r;                     // next fetch address
    logic [ies_pkg::PC_W-1:0]   pc_nxt;
    // two-cycle ops run as execute plus a flushed slot, not a stall,
    // so the host never has to wait on the core
    logic                       discard_r;                // current slot is a nop
    logic                       discard_nxt;
    logic                       retired_r;                // one-cycle done pulse
    logic [ies_pkg::DATA_W-1:0] peek_r;                   // registered read port

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // fixed field slices of the instruction word
    // literal and register address overlap; each op reads only its own
    wire [5:0]                   op_code  = instr_in[ies_pkg::OP_HI:ies_pkg::OP_LO];
    wire [2:0]                   br_code  = instr_in[ies_pkg::BR_HI:ies_pkg::BR_LO];
    wire                         dest_sel = instr_in[ies_pkg::DEST_B];
    wire [ies_pkg::ADDR_W-1:0]   f_addr   = instr_in[ies_pkg::ADDR_W-1:0];
    wire [ies_pkg::DATA_W-1:0]   lit_k    = instr_in[ies_pkg::DATA_W-1:0];
    wire [ies_pkg::LIT_W-1:0]    br_k     = instr_in[ies_pkg::LIT_W-1:0];

    // a flushed slot executes as nothing, whatever the word holds
    // a word shown while a flush is pending is swallowed here,
    // so the decode below never sees it
    wire                         live     = instr_valid_in && !discard_r;

    ies_pkg::ies_op_e op; // decoded class, nop when idle or flushed

    // operation class; branch prefix checked first since it spans op bits
    always_comb begin
        if (!live) begin
            op = ies_pkg::IES_NOP;
        end else if (br_code == ies_pkg::OPC_BRANCH) begin
            op = ies_pkg::IES_BRANCH;
        end else begin
            unique case (op_code)
                ies_pkg::OPC_CLEAR_LOC: op = ies_pkg::IES_CLEAR_LOC;
                ies_pkg::OPC_CLEAR_ACC: op = ies_pkg::IES_CLEAR_ACC;
                ies_pkg::OPC_DEC:       op = ies_pkg::IES_DEC;
                ies_pkg::OPC_DEC_SKIP:  op = ies_pkg::IES_DEC_SKIP;
                ies_pkg::OPC_INC_SKIP:  op = ies_pkg::IES_INC_SKIP;
                ies_pkg::OPC_OR_LIT:    op = ies_pkg::IES_OR_LIT;
                default:                op = ies_pkg::IES_NOP; // outside this subset
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // datapath

    // operand path; one read port serves every register op
    // both wraps are plain modulo-256 arithmetic, no carry kept
    wire [ies_pkg::DATA_W-1:0] f_val   = regs_mem[f_addr];        // operand read
    wire [ies_pkg::DATA_W-1:0] dec_val = f_val - ies_pkg::ONE_BYTE; // wraps 00h to ffh
    wire [ies_pkg::DATA_W-1:0] inc_val = f_val + ies_pkg::ONE_BYTE; // wraps ffh to 00h
    wire [ies_pkg::DATA_W-1:0] or_val  = acc_r | lit_k;

    // ops that read a register and may write it back
    wire is_arith = (op == ies_pkg::IES_DEC) || (op == ies_pkg::IES_DEC_SKIP) ||
                    (op == ies_pkg::IES_INC_SKIP);
    // only increment-skip adds; the other two subtract one
    wire [ies_pkg::DATA_W-1:0] arith_val = (op == ies_pkg::IES_INC_SKIP) ? inc_val
                                                                        : dec_val;

    // skip only on a zero result; a nonzero one runs the next word
    // the flush raised here is consumed by the next valid slot
    wire skip_hit = ((op == ies_pkg::IES_DEC_SKIP) || (op == ies_pkg::IES_INC_SKIP)) &&
                    is_zero(arith_val); // RQ5 RQ6 RQ7

    // register write port: clear or arithmetic with destination set
    // clear location never looks at the destination bit
    wire                       reg_we  = (op == ies_pkg::IES_CLEAR_LOC) ||
                                         (is_arith && dest_sel == ies_pkg::DEST_REG); // RQ3
    wire [ies_pkg::DATA_W-1:0] reg_wd  = (op == ies_pkg::IES_CLEAR_LOC) ? ies_pkg::ZERO_BYTE
                                                                       : arith_val; // RQ1

    // branch target: immediate low, two latch bits on top
    // latch is taken in the branch slot itself, so it may change just before
    wire [ies_pkg::PC_W-1:0]   br_target = {upper_latch_in[ies_pkg::LATCH_HI:ies_pkg::LATCH_LO],
                                            br_k}; // RQ8

    // next state of accumulator, flag, counter and flush
    // defaults hold state and step the counter on any valid slot;
    // a discarded slot still advances it, as a fetch would
    always_comb begin
        acc_nxt     = acc_r;
        zero_nxt    = zero_r;
        pc_nxt      = instr_valid_in ? pc_r + ies_pkg::PC_STEP : pc_r;
        discard_nxt = discard_r && !instr_valid_in; // flush waits for its slot
        unique case (op)
            ies_pkg::IES_CLEAR_LOC: begin
                // the zero byte itself goes in through the file port
                zero_nxt = 1'b1; // RQ1
            end
            ies_pkg::IES_CLEAR_ACC: begin
                acc_nxt  = ies_pkg::ZERO_BYTE; // RQ2
                zero_nxt = 1'b1; // RQ2
            end
            ies_pkg::IES_DEC: begin
                // register destination is written through the file port
                if (dest_sel == ies_pkg::DEST_ACC) begin
                    acc_nxt = dec_val; // RQ3 RQ4
                end
                zero_nxt = is_zero(dec_val); // RQ4 RQ11
            end
            ies_pkg::IES_DEC_SKIP,
            ies_pkg::IES_INC_SKIP: begin
                // status left alone on purpose
                if (dest_sel == ies_pkg::DEST_ACC) begin
                    acc_nxt = arith_val; // RQ3 RQ5 RQ6
                end
                discard_nxt = skip_hit; // RQ5 RQ6 RQ7
            end
            ies_pkg::IES_BRANCH: begin
                // next word is already fetched, so it is thrown away;
                // flags are left untouched on purpose
                pc_nxt      = br_target; // RQ8
                discard_nxt = 1'b1; // RQ9
            end
            ies_pkg::IES_OR_LIT: begin
                // literal spans the destination bit field as well
                acc_nxt  = or_val; // RQ10
                zero_nxt = is_zero(or_val); // RQ10 RQ11
            end
            ies_pkg::IES_NOP: begin
                // nothing beyond counter advance
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // control state; memory kept out since it has no reset value
    // retired counts flushed slots too, so a host can pace its fetches
    // peek adds one cycle of latency on top of the file write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_r     <= ies_pkg::ZERO_BYTE;
            zero_r    <= 1'b0;
            pc_r      <= ies_pkg::PC_RESET;
            discard_r <= 1'b0;
            retired_r <= 1'b0;
            peek_r    <= ies_pkg::ZERO_BYTE;
        end else begin
            acc_r     <= acc_nxt;
            zero_r    <= zero_nxt;
            pc_r      <= pc_nxt;
            discard_r <= discard_nxt;
            retired_r <= instr_valid_in; // also pulses for a flushed slot
            peek_r    <= regs_mem[peek_addr_in];
        end
    end

    // register file write, one location per cycle
    // no reset: clearing every byte in reset would cost a mux per bit
    // write lands at the edge, so the next instruction already reads it
    always_ff @(posedge clk_in) begin
        if (reg_we) begin
            regs_mem[f_addr] <= reg_wd; // RQ1 RQ3
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    // plain wires from the flops; no logic between them and the ports

    assign acc_out             = acc_r;
    assign zero_out            = zero_r;
    assign program_counter_out = pc_r;
    assign discard_out         = discard_r;
    assign retired_out         = retired_r;
    assign peek_data_out       = peek_r;

endmodule : ies_core

// *** testbench/ies_core_chk.sv ***
`timescale 1ns/100ps
// watches the core ports; every result lands one cycle after its slot
module ies_core_chk (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        instr_valid_in,
    input wire logic [13:0] instr_in,
    input wire logic [7:0]  upper_latch_in,
    input wire logic [7:0]  acc_out,
    input wire logic        zero_out,
    input wire logic [12:0] program_counter_out,
    input wire logic        discard_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////
    // a slot that really runs; a discarded one must leave acc_out and zero_out alone
    wire logic        ex_w  = instr_valid_in && !discard_out;
    wire logic [5:0]  op_w  = instr_in[13:8];
    wire logic        br_w  = ex_w && instr_in[13:11] == ies_pkg::OPC_BRANCH;
    wire logic        sk_w  = ex_w && (op_w == ies_pkg::OPC_DEC_SKIP ||
                                       op_w == ies_pkg::OPC_INC_SKIP);
    wire logic [12:0] tgt_w = {upper_latch_in[4:3], instr_in[10:0]};
    wire logic [7:0]  orv_w = acc_out | instr_in[7:0];
    // clear location leaves the accumulator alone and forces the flag
    property p_clr_loc;
        ex_w && op_w == ies_pkg::OPC_CLEAR_LOC |=> zero_out && $stable(acc_out);
    endproperty
    a_clr_loc: assert property (p_clr_loc) else $error("clear location flag wrong");
    property p_clr_acc;
        ex_w && op_w == ies_pkg::OPC_CLEAR_ACC |=> acc_out == 8'h00 && zero_out;
    endproperty
    a_clr_acc: assert property (p_clr_acc) else $error("clear acc wrong");
    // accumulator destination only, so the flag can be held against the result
    property p_dec;
        ex_w && op_w == ies_pkg::OPC_DEC && !instr_in[7] |=>
            zero_out == (acc_out == 8'h00) && !discard_out;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement flag wrong");
    property p_skip;
        sk_w && !instr_in[7] |=> discard_out == (acc_out == 8'h00) && $stable(zero_out);
    endproperty
    a_skip: assert property (p_skip) else $error("skip decision wrong");
    property p_nop;
        instr_valid_in && discard_out |=>
            $stable(acc_out) && $stable(zero_out) && !discard_out;
    endproperty
    a_nop: assert property (p_nop) else $error("discarded slot changed state");
    property p_branch;
        br_w |=> program_counter_out == $past(tgt_w) && discard_out && $stable(zero_out);
    endproperty
    a_branch: assert property (p_branch) else $error("branch target wrong");
    property p_pc_step;
        instr_valid_in && !br_w |=>
            program_counter_out == $past(program_counter_out) + 13'h0001;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
    property p_or_lit;
        ex_w && op_w == ies_pkg::OPC_OR_LIT |=>
            acc_out == $past(orv_w) && zero_out == (acc_out == 8'h00);
    endproperty
    a_or_lit: assert property (p_or_lit) else $error("or literal wrong");
    c_branch: cover property (br_w);
    c_skip: cover property (sk_w ##1 discard_out);
    c_nop: cover property (instr_valid_in && discard_out);
endmodule : ies_core_chk

// *** testbench/tb_ies_core.sv ***
`timescale 1ns/100ps
module tb_ies_core;
    // one row: word, then acc, zero and discard one cycle later
    typedef struct {logic [13:0] w; logic [7:0] a; logic z; logic d;} ies_row_s;
    localparam logic [5:0] CL = ies_pkg::OPC_CLEAR_LOC, CA = ies_pkg::OPC_CLEAR_ACC;
    localparam logic [5:0] DC = ies_pkg::OPC_DEC, DS = ies_pkg::OPC_DEC_SKIP;
    localparam logic [5:0] IS = ies_pkg::OPC_INC_SKIP, OR = ies_pkg::OPC_OR_LIT;
    localparam logic [6:0] F = 7'h05, G = 7'h7f; // low and top register
    logic        clk_in = 1'b0, rst_in = 1'b1, instr_valid_in = 1'b0;
    logic [13:0] instr_in = 14'h0000;
    logic [7:0]  upper_latch_in = 8'h00, acc_out, peek_data_out;
    logic [6:0]  peek_addr_in = 7'h00;
    logic        zero_out, discard_out, retired_out;
    logic [12:0] program_counter_out;
    int          err_total = 0, n_tests = 0;
    ies_row_s    rows[13];
    always #2.5 clk_in = ~clk_in;
    ies_core i_dut (.clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .upper_latch_in(upper_latch_in), .peek_addr_in(peek_addr_in),
        .acc_out(acc_out), .zero_out(zero_out), .program_counter_out(program_counter_out),
        .discard_out(discard_out), .retired_out(retired_out), .peek_data_out(peek_data_out));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [13:0] iw(logic [5:0] o, logic d, logic [6:0] f);
        return {o, d, f};
    endfunction : iw
    task automatic chk(logic [12:0] g, logic [12:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // byte results, widened on purpose to the shared compare
    task automatic chk_byte(logic [7:0] g, logic [7:0] e);
        chk({5'h00, g}, {5'h00, e});
    endtask : chk_byte
    // single-bit results
    task automatic chk_bit(logic g, logic e);
        chk({12'h000, g}, {12'h000, e});
    endtask : chk_bit
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    // word driven at one edge, taken at the next; valid drops there,
    // so an idle slot follows and each result stays up to be read
    task automatic step(logic [13:0] w);
        @(posedge clk_in);
        instr_in <= w;
        instr_valid_in <= 1'b1;
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        #1;
    endtask : step
    // every output at its reset value
    task automatic rst_chk();
        chk_byte(acc_out, 8'h00);
        chk_bit(zero_out, 1'b0);
        chk(program_counter_out, 13'h0000);
        chk_bit(discard_out, 1'b0);
        chk_bit(retired_out, 1'b0);
        chk_byte(peek_data_out, 8'h00);
    endtask : rst_chk
    // hang guard, far beyond the roughly fifty cycles used
    initial begin
        #3000;
        err_total++;
        close_out();
    end
    initial begin
        rows[0]  = '{iw(CL, 1'b0, F), 8'h00, 1'b1, 1'b0};     // clear register 5
        rows[1]  = '{iw(DC, 1'b1, F), 8'h00, 1'b0, 1'b0};     // register 5 wraps to ff
        rows[2]  = '{iw(IS, 1'b0, F), 8'h00, 1'b0, 1'b1};     // ff plus one skips
        rows[3]  = '{iw(OR, 1'b1, 7'h7f), 8'h00, 1'b0, 1'b0}; // flushed slot
        rows[4]  = '{iw(OR, 1'b0, 7'h00), 8'h00, 1'b1, 1'b0};
        rows[5]  = '{iw(OR, 1'b0, 7'h5a), 8'h5a, 1'b0, 1'b0};
        rows[6]  = '{iw(CA, 1'b0, 7'h00), 8'h00, 1'b1, 1'b0};
        rows[7]  = '{iw(DC, 1'b0, F), 8'hfe, 1'b0, 1'b0};
        rows[8]  = '{iw(DS, 1'b1, F), 8'hfe, 1'b0, 1'b0};     // nonzero, no skip
        rows[9]  = '{iw(CL, 1'b0, G), 8'hfe, 1'b1, 1'b0};
        rows[10] = '{iw(IS, 1'b1, G), 8'hfe, 1'b1, 1'b0};
        rows[11] = '{iw(DS, 1'b0, G), 8'h00, 1'b1, 1'b1};     // 01 minus one skips
        rows[12] = '{iw(OR, 1'b1, 7'h01), 8'h00, 1'b1, 1'b0}; // flushed slot
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        rst_chk();
        $display("reset done");
        for (int i = 0; i < 13; i++) begin
            step(rows[i].w);
            chk_byte(acc_out, rows[i].a);
            chk_bit(zero_out, rows[i].z);
            chk_bit(discard_out, rows[i].d);
            chk(program_counter_out, 13'(i + 1));
            chk_bit(retired_out, 1'b1);
        end
        $display("table rows done");
        @(posedge clk_in);
        upper_latch_in <= 8'h18;
        step({ies_pkg::OPC_BRANCH, 11'h7ff});
        chk(program_counter_out, 13'h1fff);
        chk_bit(discard_out, 1'b1);
        chk_bit(zero_out, 1'b1);
        step(iw(OR, 1'b0, 7'h33));
        chk_byte(acc_out, 8'h00);
        chk(program_counter_out, 13'h0000);
        chk_bit(discard_out, 1'b0);
        @(posedge clk_in);
        upper_latch_in <= 8'hf7;
        step({ies_pkg::OPC_BRANCH, 11'h2aa});
        chk(program_counter_out, 13'h12aa);
        $display("branch done");
        @(posedge clk_in);
        peek_addr_in <= F;
        repeat (2) @(posedge clk_in);
        #1;
        chk_byte(peek_data_out, 8'hfe);
        chk_bit(retired_out, 1'b0);
        @(posedge clk_in);
        peek_addr_in <= G;
        repeat (2) @(posedge clk_in);
        #1;
        chk_byte(peek_data_out, 8'h01);
        $display("register file done");
        @(posedge clk_in);
        rst_in <= 1'b1;
        @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        rst_chk();
        // first word after a mid-run reset must run normally
        step(iw(OR, 1'b0, 7'h3c));
        chk_byte(acc_out, 8'h3c);
        chk_bit(zero_out, 1'b0);
        chk(program_counter_out, 13'h0001);
        $display("second reset done");
        close_out();
    end
endmodule : tb_ies_core
bind ies_core ies_core_chk i_chk (.clk_in(clk_in), .rst_in(rst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in), .upper_latch_in(upper_latch_in),
    .acc_out(acc_out), .zero_out(zero_out), .program_counter_out(program_counter_out),
    .discard_out(discard_out));
